// ### core/cib_top.sv
// Notes on behaviour
// [R1] 0x82 holds transmit insert enables, channel 17 at bit 0 to 24.
// [R2] 0x83 holds transmit insert enables, channel 25 at bit 0 to 32.
// [R3] transmit enable set: channel byte replaced by idle code, else passes.
// [R4] receive enable set: channel byte replaced by idle code, else passes.
// [R5] 0x84 holds receive insert enables, channel 1 at bit 0.
// [R6] 0x85 holds receive insert enables, channel 9 at bit 0.
// [R7] 0x86 holds receive insert enables, channel 17 at bit 0.
// [R8] 0x87 holds receive insert enables, channel 25 at bit 0.
// [R9] t1 framing serves 24 channels, e1 framing serves 32.
// [R10] receive block bank drives receive output, transmit bank transmit one.
// [R11] block bit set: output high for the whole channel time.
// [R12] block bit clear: output low for the whole channel time.
// [R13] in t1 framing, block bits for channels 25 to 32 are ignored.
// [R14] 0x88 holds receive block bits, channel 1 at bit 0 to 8.
// [R15] 0x89 holds receive block bits, channel 9 at bit 0.
// [R16] 0x8a holds receive block bits, channel 17 at bit 0.
// [R17] 0x8b holds receive block bits, channel 25 at bit 0.
// [R18] outside controller may gate its clock with the block outputs.
// [R19] idle code is one byte, sent most significant bit first.
// [R20] array of 64: 0-31 transmit channels, 32-63 receive channels.
// [R21] registers reset to zero, read back, act from next channel start.
// [R22] block outputs change only on their own channel boundaries.
`timescale 1ns/100ps
`default_nettype none
module cib_top
  import cib_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // parallel port
  input wire logic reg_cs,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // framing mode
  input wire logic e1_mode,
  // transmit stream
  input wire logic tx_bit_en,
  input wire logic tx_frame_start,
  input wire logic tx_data_in,
  output logic tx_data_out,
  output logic tx_channel_block_out,
  // receive stream
  input wire logic rx_bit_en,
  input wire logic rx_frame_start,
  input wire logic rx_data_in,
  output logic rx_data_out,
  output logic rx_channel_block_out
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] get_byte(logic [31:0] v, logic [1:0] b);
    get_byte = v[8*b +: 8];
  endfunction

  function automatic logic [31:0] put_byte(logic [31:0] v, logic [1:0] b,
                                           logic [7:0] d);
    logic [31:0] r;
    r = v;
    r[8*b +: 8] = d;
    put_byte = r;
  endfunction

  // ----------------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------------
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic [31:0] tx_en_q;
  logic [31:0] tx_en_d;
  logic [31:0] rx_en_q;
  logic [31:0] rx_en_d;
  logic [31:0] tx_blk_q;
  logic [31:0] tx_blk_d;
  logic [31:0] rx_blk_q;
  logic [31:0] rx_blk_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic wr_hit;
  logic rd_hit;
  logic in_bank;
  logic [7:0] bank_off;
  logic [1:0] grp;
  logic [1:0] byt;
  logic code_wr;
  logic [7:0] cpu_code;

  always_comb
  begin
    wr_hit = reg_cs && reg_wr;
    rd_hit = reg_cs && reg_rd;
    in_bank = (reg_addr >= CIB_OFS_TX_EN_CH1_8) &&
              (reg_addr <= CIB_OFS_TX_BLK_CH25_32);
    bank_off = reg_addr - CIB_OFS_TX_EN_CH1_8;
    grp = bank_off[3:2];
    byt = bank_off[1:0];
    code_wr = wr_hit && (reg_addr == CIB_OFS_CODE);
    ptr_d = ptr_q;
    tx_en_d = tx_en_q;
    rx_en_d = rx_en_q;
    tx_blk_d = tx_blk_q;
    rx_blk_d = rx_blk_q;
    rdata_d = rdata_q;
    if (wr_hit && (reg_addr == CIB_OFS_PTR))
      ptr_d = reg_wdata;
    // successive code writes walk through the array
    if (code_wr)
      ptr_d[CIB_IDX_W-1:0] = ptr_q[CIB_IDX_W-1:0] + 6'h01;
    if (wr_hit && in_bank)
    begin
      unique case (grp)
        CIB_GRP_TX_EN: tx_en_d = put_byte(tx_en_q, byt, reg_wdata); // [R1] [R2]
        CIB_GRP_RX_EN: rx_en_d = put_byte(rx_en_q, byt, reg_wdata); // [R5] [R6] [R7] [R8]
        CIB_GRP_RX_BLK: rx_blk_d = put_byte(rx_blk_q, byt, reg_wdata); // [R14] [R15] [R16] [R17]
        CIB_GRP_TX_BLK: tx_blk_d = put_byte(tx_blk_q, byt, reg_wdata);
      endcase
    end
    if (rd_hit)
    begin
      rdata_d = CIB_BYTE_RST;
      if (reg_addr == CIB_OFS_PTR)
        rdata_d = ptr_q;
      else if (reg_addr == CIB_OFS_CODE)
        rdata_d = cpu_code;
      else if (in_bank)
      begin
        unique case (grp)
          CIB_GRP_TX_EN: rdata_d = get_byte(tx_en_q, byt); // [R21]
          CIB_GRP_RX_EN: rdata_d = get_byte(rx_en_q, byt);
          CIB_GRP_RX_BLK: rdata_d = get_byte(rx_blk_q, byt);
          CIB_GRP_TX_BLK: rdata_d = get_byte(tx_blk_q, byt);
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ptr_q <= CIB_BYTE_RST;
      tx_en_q <= CIB_BANK_RST; // [R21]
      rx_en_q <= CIB_BANK_RST;
      tx_blk_q <= CIB_BANK_RST;
      rx_blk_q <= CIB_BANK_RST;
      rdata_q <= CIB_BYTE_RST;
    end
    else
    begin
      ptr_q <= ptr_d;
      tx_en_q <= tx_en_d;
      rx_en_q <= rx_en_d;
      tx_blk_q <= tx_blk_d;
      rx_blk_q <= rx_blk_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------------
  // timeslot timers and idle code array
  // ----------------------------------------------------------------------
  logic [4:0] chan [2];
  logic [2:0] bitn [2];
  logic in_chan [2];
  logic [7:0] code_rd [2];
  logic bit_en [2];
  logic data_in [2];

  assign bit_en[CIB_DIR_TX] = tx_bit_en;
  assign bit_en[CIB_DIR_RX] = rx_bit_en;
  assign data_in[CIB_DIR_TX] = tx_data_in;
  assign data_in[CIB_DIR_RX] = rx_data_in;

  cib_slot_timer u_tx_timer (
    .clk(clk),
    .rst_n(rst_n),
    .bit_en(tx_bit_en),
    .frame_start(tx_frame_start),
    .e1_mode(e1_mode),
    .chan(chan[CIB_DIR_TX]),
    .bitn(bitn[CIB_DIR_TX]),
    .in_chan(in_chan[CIB_DIR_TX])
  );

  cib_slot_timer u_rx_timer (
    .clk(clk),
    .rst_n(rst_n),
    .bit_en(rx_bit_en),
    .frame_start(rx_frame_start),
    .e1_mode(e1_mode),
    .chan(chan[CIB_DIR_RX]),
    .bitn(bitn[CIB_DIR_RX]),
    .in_chan(in_chan[CIB_DIR_RX])
  );

  cib_idle_array #(
    .DEPTH(64),
    .WIDTH(8)
  ) u_array (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(code_wr),
    .wr_idx(ptr_q[CIB_IDX_W-1:0]),
    .wr_all_tx(ptr_q[CIB_PTR_ALL_TX_BIT]),
    .wr_all_rx(ptr_q[CIB_PTR_ALL_RX_BIT]),
    .wr_data(reg_wdata),
    .rd_idx_tx({CIB_DIR_TX, chan[CIB_DIR_TX]}), // [R20]
    .rd_idx_rx({CIB_DIR_RX, chan[CIB_DIR_RX]}), // [R20]
    .rd_idx_cpu(ptr_q[CIB_IDX_W-1:0]),
    .rd_data_tx(code_rd[CIB_DIR_TX]),
    .rd_data_rx(code_rd[CIB_DIR_RX]),
    .rd_data_cpu(cpu_code)
  );

  // ----------------------------------------------------------------------
  // per-direction insertion and blocking
  // ----------------------------------------------------------------------
  // settings are sampled at a channel's first bit and held for its
  // remaining seven, so a mid-slot write never splits a byte or a pulse
  logic slot_ins_q [2];
  logic slot_ins_d [2];
  logic slot_blk_q [2];
  logic slot_blk_d [2];
  logic [7:0] slot_code_q [2];
  logic [7:0] slot_code_d [2];
  logic dout_q [2];
  logic dout_d [2];
  logic blk_q [2];
  logic blk_d [2];

  always_comb
  begin
    for (int d = 0; d < 2; d++)
    begin
      logic first;
      logic chan_ok;
      logic ins_now;
      logic blk_now;
      logic [7:0] code_now;
      logic [31:0] en_vec;
      logic [31:0] blk_vec;
      en_vec = (d == 1) ? rx_en_q : tx_en_q;
      blk_vec = (d == 1) ? rx_blk_q : tx_blk_q; // [R10]
      chan_ok = e1_mode || (chan[d] < CIB_T1_CHAN_LIMIT); // [R9] [R13]
      first = in_chan[d] && (bitn[d] == 3'h0);
      ins_now = first ? (en_vec[chan[d]] && chan_ok) : slot_ins_q[d]; // [R21]
      blk_now = first ? (blk_vec[chan[d]] && chan_ok) : slot_blk_q[d];
      code_now = first ? code_rd[d] : slot_code_q[d];
      slot_ins_d[d] = slot_ins_q[d];
      slot_blk_d[d] = slot_blk_q[d];
      slot_code_d[d] = slot_code_q[d];
      dout_d[d] = dout_q[d];
      blk_d[d] = blk_q[d];
      if (bit_en[d])
      begin
        if (first)
        begin
          slot_ins_d[d] = ins_now;
          slot_blk_d[d] = blk_now;
          slot_code_d[d] = code_now;
        end
        // [R3] [R4] [R19]
        dout_d[d] = (in_chan[d] && ins_now) ?
                    code_now[CIB_CODE_MSB - bitn[d]] : data_in[d];
        // [R11] [R12] [R22]
        blk_d[d] = in_chan[d] && blk_now;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    for (int d = 0; d < 2; d++)
    begin
      if (!rst_n)
      begin
        slot_ins_q[d] <= 1'b0;
        slot_blk_q[d] <= 1'b0;
        slot_code_q[d] <= CIB_BYTE_RST;
        dout_q[d] <= 1'b0;
        blk_q[d] <= 1'b0;
      end
      else
      begin
        slot_ins_q[d] <= slot_ins_d[d];
        slot_blk_q[d] <= slot_blk_d[d];
        slot_code_q[d] <= slot_code_d[d];
        dout_q[d] <= dout_d[d];
        blk_q[d] <= blk_d[d];
      end
    end
  end

  assign tx_data_out = dout_q[CIB_DIR_TX];
  assign rx_data_out = dout_q[CIB_DIR_RX];
  assign tx_channel_block_out = blk_q[CIB_DIR_TX]; // [R10]
  assign rx_channel_block_out = blk_q[CIB_DIR_RX]; // [R10]

endmodule
`default_nettype wire

// ### core/cib_pkg.sv
package cib_pkg;

  // ----------------------------------------------------------------------
  // register offsets on the 8-bit parallel port
  // ----------------------------------------------------------------------
  localparam logic [7:0] CIB_OFS_PTR = 8'h7e;
  localparam logic [7:0] CIB_OFS_CODE = 8'h7f;
  localparam logic [7:0] CIB_OFS_TX_EN_CH1_8 = 8'h80;
  localparam logic [7:0] CIB_OFS_TX_EN_CH9_16 = 8'h81;
  localparam logic [7:0] CIB_OFS_TX_EN_CH17_24 = 8'h82;
  localparam logic [7:0] CIB_OFS_TX_EN_CH25_32 = 8'h83;
  localparam logic [7:0] CIB_OFS_RX_EN_CH1_8 = 8'h84;
  localparam logic [7:0] CIB_OFS_RX_EN_CH9_16 = 8'h85;
  localparam logic [7:0] CIB_OFS_RX_EN_CH17_24 = 8'h86;
  localparam logic [7:0] CIB_OFS_RX_EN_CH25_32 = 8'h87;
  localparam logic [7:0] CIB_OFS_RX_BLK_CH1_8 = 8'h88;
  localparam logic [7:0] CIB_OFS_RX_BLK_CH9_16 = 8'h89;
  localparam logic [7:0] CIB_OFS_RX_BLK_CH17_24 = 8'h8a;
  localparam logic [7:0] CIB_OFS_RX_BLK_CH25_32 = 8'h8b;
  localparam logic [7:0] CIB_OFS_TX_BLK_CH1_8 = 8'h8c;
  localparam logic [7:0] CIB_OFS_TX_BLK_CH9_16 = 8'h8d;
  localparam logic [7:0] CIB_OFS_TX_BLK_CH17_24 = 8'h8e;
  localparam logic [7:0] CIB_OFS_TX_BLK_CH25_32 = 8'h8f;

  // ----------------------------------------------------------------------
  // bank groups inside 0x80..0x8f, four bytes each
  // ----------------------------------------------------------------------
  localparam logic [1:0] CIB_GRP_TX_EN = 2'h0;
  localparam logic [1:0] CIB_GRP_RX_EN = 2'h1;
  localparam logic [1:0] CIB_GRP_RX_BLK = 2'h2;
  localparam logic [1:0] CIB_GRP_TX_BLK = 2'h3;

  // ----------------------------------------------------------------------
  // pointer fields and reset values
  // ----------------------------------------------------------------------
  localparam int CIB_PTR_ALL_RX_BIT = 7;
  localparam int CIB_PTR_ALL_TX_BIT = 6;
  localparam int CIB_IDX_W = 6;
  localparam logic CIB_DIR_TX = 1'h0;
  localparam logic CIB_DIR_RX = 1'h1;
  localparam logic [7:0] CIB_BYTE_RST = 8'h00;
  localparam logic [31:0] CIB_BANK_RST = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------------
  localparam logic [7:0] CIB_T1_POS_LAST = 8'hc0;
  localparam logic [7:0] CIB_E1_POS_LAST = 8'hff;
  localparam logic [7:0] CIB_T1_FBIT_POS = 8'h00;
  localparam logic [4:0] CIB_T1_CHAN_LIMIT = 5'h18;
  localparam logic [2:0] CIB_CODE_MSB = 3'h7;

endpackage

// ### core/cib_slot_timer.sv
`timescale 1ns/100ps
`default_nettype none
module cib_slot_timer
  import cib_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // framing timing
  input wire logic bit_en,
  input wire logic frame_start,
  input wire logic e1_mode,
  // position of the bit in this cycle
  output logic [4:0] chan,
  output logic [2:0] bitn,
  output logic in_chan
);

  // ----------------------------------------------------------------------
  // bit position within the frame
  // ----------------------------------------------------------------------
  logic [7:0] pos_q;
  logic [7:0] pos_d;
  logic [7:0] cur;
  logic [7:0] off;
  logic [7:0] last;

  always_comb
  begin
    last = e1_mode ? CIB_E1_POS_LAST : CIB_T1_POS_LAST;
    if (frame_start)
      cur = CIB_T1_FBIT_POS;
    else if (pos_q == last)
      cur = CIB_T1_FBIT_POS;
    else
      cur = pos_q + 8'h01;
    pos_d = bit_en ? cur : pos_q;
    // t1 carries the framing bit ahead of channel 1
    off = e1_mode ? cur : cur - 8'h01;
    in_chan = e1_mode || (cur != CIB_T1_FBIT_POS);
    chan = off[7:3];
    bitn = off[2:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pos_q <= CIB_T1_FBIT_POS;
    else
      pos_q <= pos_d;
  end

endmodule
`default_nettype wire

// ### core/cib_idle_array.sv
`timescale 1ns/100ps
`default_nettype none
module cib_idle_array
  import cib_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int WIDTH = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write port
  input wire logic wr_en,
  input wire logic [CIB_IDX_W-1:0] wr_idx,
  input wire logic wr_all_tx,
  input wire logic wr_all_rx,
  input wire logic [WIDTH-1:0] wr_data,
  // read ports
  input wire logic [CIB_IDX_W-1:0] rd_idx_tx,
  input wire logic [CIB_IDX_W-1:0] rd_idx_rx,
  input wire logic [CIB_IDX_W-1:0] rd_idx_cpu,
  output logic [WIDTH-1:0] rd_data_tx,
  output logic [WIDTH-1:0] rd_data_rx,
  output logic [WIDTH-1:0] rd_data_cpu
);

  // ----------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------
  if (DEPTH != 64 || WIDTH != 8)
  begin : g_bad
    $error("idle array must be 64 entries of 8 bits");
  end

  // ----------------------------------------------------------------------
  // storage: lower half transmit, upper half receive
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];

  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      logic [CIB_IDX_W-1:0] ii;
      ii = CIB_IDX_W'(i);
      mem_d[i] = mem_q[i];
      if (wr_en && ((ii == wr_idx) || (wr_all_tx && !ii[CIB_IDX_W-1]) ||
          (wr_all_rx && ii[CIB_IDX_W-1])))
        mem_d[i] = wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      if (!rst_n)
        mem_q[i] <= CIB_BYTE_RST;
      else
        mem_q[i] <= mem_d[i];
    end
  end

  assign rd_data_tx = mem_q[rd_idx_tx];
  assign rd_data_rx = mem_q[rd_idx_rx];
  assign rd_data_cpu = mem_q[rd_idx_cpu];

endmodule
`default_nettype wire

// ### test/cib_chk.sv
`timescale 1ns/100ps
`default_nettype none
module cib_chk
  import cib_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic reg_cs,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // streams
  input wire logic tx_bit_en,
  input wire logic tx_data_in,
  input wire logic tx_data_out,
  input wire logic tx_channel_block_out,
  input wire logic rx_bit_en,
  input wire logic rx_data_in,
  input wire logic rx_data_out,
  input wire logic rx_channel_block_out
);
  // ----------
  // groups written non-zero since reset
  // ----------
  // stays set once marked: cheap, and never wrong in the safe direction
  logic [3:0] dirty_q;
  logic [3:0] dirty_d;
  always_comb
  begin
    dirty_d = dirty_q;
    if (reg_cs && reg_wr && reg_addr[7:4] == 4'h8 && reg_wdata != 8'h00)
      dirty_d[reg_addr[3:2]] = 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      dirty_q <= 4'h0;
    else
      dirty_q <= dirty_d;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_tx_pass_clean: assert property (
    tx_bit_en && !dirty_q[CIB_GRP_TX_EN] |=>
    tx_data_out == $past(tx_data_in)) else $error("tx data altered");
  a_rx_pass_clean: assert property (
    rx_bit_en && !dirty_q[CIB_GRP_RX_EN] |=>
    rx_data_out == $past(rx_data_in)) else $error("rx data altered");
  a_tx_blk_low: assert property (
    tx_bit_en && !dirty_q[CIB_GRP_TX_BLK] |=> !tx_channel_block_out)
    else $error("tx block raised");
  a_rx_blk_low: assert property (
    rx_bit_en && !dirty_q[CIB_GRP_RX_BLK] |=> !rx_channel_block_out)
    else $error("rx block raised");
  a_tx_out_hold: assert property (
    !tx_bit_en |=> $stable(tx_channel_block_out) && $stable(tx_data_out))
    else $error("tx output moved between bits");
  a_rx_out_hold: assert property (
    !rx_bit_en |=> $stable(rx_channel_block_out) && $stable(rx_data_out))
    else $error("rx output moved between bits");
  a_reset_zero: assert property (
    $rose(rst_n) |-> !tx_data_out && !rx_data_out && reg_rdata == 8'h00
    && !tx_channel_block_out && !rx_channel_block_out)
    else $error("output not zero after reset");
  a_unmapped_zero: assert property (
    reg_cs && reg_rd && !reg_wr && (reg_addr < 8'h7e || reg_addr > 8'h8f)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  // the write task drops its strobe for one edge before a read can follow
  a_bank_readback: assert property (
    reg_cs && reg_wr && reg_addr[7:4] == 4'h8 ##1 !reg_cs ##1
    reg_cs && reg_rd && !reg_wr && reg_addr == $past(reg_addr, 2) |=>
    reg_rdata == $past(reg_wdata, 3)) else $error("readback mismatch");
  a_rdata_hold: assert property (
    !(reg_cs && reg_rd) |=> $stable(reg_rdata))
    else $error("read data moved without a read");
endmodule

bind cib_top cib_chk u_chk (
  .clk(clk), .rst_n(rst_n), .reg_cs(reg_cs), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .tx_bit_en(tx_bit_en), .tx_data_in(tx_data_in),
  .tx_data_out(tx_data_out), .tx_channel_block_out(tx_channel_block_out),
  .rx_bit_en(rx_bit_en), .rx_data_in(rx_data_in),
  .rx_data_out(rx_data_out), .rx_channel_block_out(rx_channel_block_out)
);
`default_nettype wire

// ### test/cib_gated_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module cib_gated_ctrl
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // line timing and gated channel
  input wire logic bit_en,
  input wire logic data,
  input wire logic gate,
  // collected traffic
  output logic [15:0] bits_taken,
  output logic [7:0] last_byte
);
  // ----------
  // controller clocked only while the gate is high
  // ----------
  // samples one cycle after the bit strobe, once the outputs have settled
  logic seen_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      seen_q <= 1'b0;
      bits_taken <= 16'h0000;
      last_byte <= 8'h00;
    end
    else
    begin
      seen_q <= bit_en;
      if (seen_q && gate)
      begin
        bits_taken <= bits_taken + 16'h0001;
        last_byte <= {last_byte[6:0], data};
      end
    end
  end
endmodule
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import cib_pkg::*;
;
  logic clk, rst_n, reg_cs, reg_wr, reg_rd, e1_mode;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ptx_byte, prx_byte;
  logic tx_bit_en, tx_frame_start, tx_data_in, tx_data_out;
  logic rx_bit_en, rx_frame_start, rx_data_in, rx_data_out;
  logic tx_channel_block_out, rx_channel_block_out;
  logic [15:0] ptx_bits, prx_bits;
  logic [31:0] bank [4];
  logic [7:0] code [64];
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;

  cib_top u_dut (.clk(clk), .rst_n(rst_n), .reg_cs(reg_cs),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .e1_mode(e1_mode),
    .tx_bit_en(tx_bit_en), .tx_frame_start(tx_frame_start),
    .tx_data_in(tx_data_in), .tx_data_out(tx_data_out),
    .tx_channel_block_out(tx_channel_block_out), .rx_bit_en(rx_bit_en),
    .rx_frame_start(rx_frame_start), .rx_data_in(rx_data_in),
    .rx_data_out(rx_data_out), .rx_channel_block_out(rx_channel_block_out));
  cib_gated_ctrl u_ptx (.clk(clk), .rst_n(rst_n), .bit_en(tx_bit_en),
    .data(tx_data_out), .gate(tx_channel_block_out),
    .bits_taken(ptx_bits), .last_byte(ptx_byte));
  cib_gated_ctrl u_prx (.clk(clk), .rst_n(rst_n), .bit_en(rx_bit_en),
    .data(rx_data_out), .gate(rx_channel_block_out),
    .bits_taken(prx_bits), .last_byte(prx_byte));

  // ----------
  // clock, timeout, reporting
  // ----------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 12000)
    begin
      err_total = err_total + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ----------
  // register port and stream drivers
  // ----------
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (19) @(posedge clk);
    rst_n <= 1'b1;
    foreach (bank[g]) bank[g] = 32'h0;
    foreach (code[i]) code[i] = 8'h00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_cs <= 1'b1;
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_cs <= 1'b0;
    reg_wr <= 1'b0;
  endtask
  // a write, one idle edge, then a read of the same place
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    rdchk(a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_cs <= 1'b1;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_cs <= 1'b0;
    reg_rd <= 1'b0;
    #1 check(16'(reg_rdata), 16'(e));
  endtask
  task automatic set_bank(input int g, input logic [31:0] v);
    bank[g] = v;
    for (int k = 0; k < 4; k++)
      wr(8'(CIB_OFS_TX_EN_CH1_8 + g * 4 + k), v[k*8 +: 8]);
  endtask
  task automatic run_frame(input logic e1);
    int q;
    logic dt, dr, et, er, bt, br;
    logic [7:0] st, sr;
    logic [15:0] t0, r0, nt, nr;
    @(posedge clk);
    e1_mode <= e1;
    {t0, r0, st, sr, nt, nr} = {ptx_bits, prx_bits, ptx_byte, prx_byte, 32'h0};
    for (int p = 0; p < (e1 ? 256 : 193); p++)
    begin
      q = (e1 || p == 0) ? p : p - 1;
      dt = p[0] ^ p[2] ^ p[5];
      dr = ~(p[1] ^ p[3]);
      @(posedge clk);
      {tx_bit_en, rx_bit_en} <= 2'h3;
      {tx_frame_start, rx_frame_start} <= {2{p == 0}};
      {tx_data_in, rx_data_in} <= {dt, dr};
      @(posedge clk);
      {tx_bit_en, rx_bit_en, tx_frame_start, rx_frame_start} <= 4'h0;
      // the framing bit of t1 is never replaced nor blocked
      et = (e1 || p != 0) && bank[0][q/8] ? code[q/8][7-q%8] : dt;
      er = (e1 || p != 0) && bank[1][q/8] ? code[32+q/8][7-q%8] : dr;
      br = (e1 || p != 0) && bank[2][q/8];
      bt = (e1 || p != 0) && bank[3][q/8];
      st = bt ? {st[6:0], et} : st;
      sr = br ? {sr[6:0], er} : sr;
      nt = nt + 16'(bt);
      nr = nr + 16'(br);
      #1 check(16'(tx_data_out), 16'(et));
      check(16'(rx_data_out), 16'(er));
      check(16'(tx_channel_block_out), 16'(bt));
      check(16'(rx_channel_block_out), 16'(br));
    end
    repeat (2) @(posedge clk);
    #1 check(ptx_bits - t0, nt);
    check(prx_bits - r0, nr);
    check(16'(ptx_byte), 16'(st));
    check(16'(prx_byte), 16'(sr));
  endtask

  // ----------
  // scenarios
  // ----------
  task automatic t_reset_values();
    for (int a = 'h7e; a <= 'h8f; a++)
      rdchk(8'(a), 8'h00);
    wr(8'h90, 8'hff);
    rdchk(8'h90, 8'h00);
  endtask
  task automatic t_readback();
    for (int a = 'h80; a <= 'h87; a++)
      wr_rd(8'(a), 8'(a * 5 + 1));
    for (int a = 'h88; a <= 'h8f; a++)
      wr_rd(8'(a), 8'(a * 5 + 1));
  endtask
  task automatic t_e1();
    wr(CIB_OFS_PTR, 8'h00);
    for (int i = 0; i < 64; i++)
    begin
      code[i] = 8'(i * 37 + 5);
      wr(CIB_OFS_CODE, code[i]);
    end
    rdchk(CIB_OFS_PTR, 8'h00);
    wr(CIB_OFS_PTR, 8'h2a);
    rdchk(CIB_OFS_CODE, code[42]);
    set_bank(0, 32'h81c3_8118);
    set_bank(1, 32'h9981_8142);
    set_bank(2, 32'h8118_81c3);
    set_bank(3, 32'hc381_2481);
    run_frame(1'b1);
  endtask
  task automatic t_t1();
    run_frame(1'b0);
  endtask
  task automatic t_global();
    wr(CIB_OFS_PTR, 8'h45);
    wr(CIB_OFS_CODE, 8'h7e);
    rdchk(CIB_OFS_PTR, 8'h46);
    wr(CIB_OFS_PTR, 8'ha3);
    wr(CIB_OFS_CODE, 8'he7);
    foreach (code[i]) code[i] = i < 32 ? 8'h7e : 8'he7;
    set_bank(0, 32'hffff_ffff);
    set_bank(1, 32'hffff_ffff);
    run_frame(1'b1);
  endtask

  initial
  begin
    rst_n = 1'b0;
    {reg_cs, reg_wr, reg_rd, tx_bit_en, rx_bit_en} = 5'h0;
    {tx_frame_start, rx_frame_start, tx_data_in, rx_data_in} = 4'h0;
    {reg_addr, reg_wdata, e1_mode} = 17'h1;
    do_reset();
    t_reset_values();
    run_frame(1'b1);
    t_readback();
    t_e1();
    t_t1();
    t_global();
    do_reset();
    t_reset_values();
    t_t1();
    end_of_test();
  end
endmodule
`default_nettype wire
